// ---- rtl/parity_xcvr_pkg.sv ----
// constants and types for the dual parity bus transceiver
package parity_xcvr_pkg;
    localparam int          BUS_W      = 8;
    localparam int          FIFO_DEPTH = 8;
    localparam int          FIFO_AW    = 3;
    localparam int          WORD_W     = BUS_W + 1;
    localparam logic        FLAG_RST   = 1'b1;
    typedef enum logic [1:0] {
        MODE_A_TO_B,
        MODE_B_TO_A,
        MODE_ISOLATE,
        MODE_A_TO_B_INV
    } xfer_mode_t;
endpackage : parity_xcvr_pkg

// ---- rtl/word_fifo.sv ----
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/10ps
module word_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready    = (count != (AW+1)'(DEPTH));
        out_valid   = (count != '0);
        push        = in_valid && in_ready;
        pop         = out_valid && out_ready;
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count  <= '0;
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            count  <= next_count;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign out_data = mem[rd_ptr];
endmodule : word_fifo

// ---- rtl/dual_parity_bus_transceiver.sv ----
// two-section 8-bit to 9-bit parity bus transceiver with error flags
//
// What this block does
// - two identical sections, each A bus, B bus, check bit, clock, clear, flag
// - b enable low, a enable high: drive B with A, check bit odd-parity low
// - b enable high, a enable low: drive A with B, check bit is input
// - check result high when B plus check bit has odd high count
// - flag updates only on sample clock rising edge with clear high
// - clear low forces flag high regardless of everything else
// - sampled flag goes low on low check or already low; errors stick
// - flag is open drain: only pulls low or releases
// - both enables high: A, B and check bit all released
// - isolation: clocked flag checks A bus, goes low on even high count of A
// - both enables low: pass A to B with deliberately inverted parity
`timescale 1ns/10ps
module dual_parity_bus_transceiver
    import parity_xcvr_pkg::*;
(
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // shared enables
    input  wire logic                  a_side_drive_enable_n,
    input  wire logic                  b_side_drive_enable_n,
    // section 1 pins
    input  wire logic [parity_xcvr_pkg::BUS_W-1:0] s1_a_in,
    output logic      [parity_xcvr_pkg::BUS_W-1:0] s1_a_out,
    output logic                       s1_a_oe,
    input  wire logic [parity_xcvr_pkg::BUS_W-1:0] s1_b_in,
    output logic      [parity_xcvr_pkg::BUS_W-1:0] s1_b_out,
    output logic                       s1_b_oe,
    input  wire logic                  section1_check_bit_in,
    output logic                       section1_check_bit_out,
    output logic                       section1_check_bit_oe,
    input  wire logic                  section1_sample_clock,
    input  wire logic                  section1_flag_clear_n,
    output logic                       section1_parity_fault_n_out,
    output logic                       section1_parity_fault_n_oe,
    // section 2 pins
    input  wire logic [parity_xcvr_pkg::BUS_W-1:0] s2_a_in,
    output logic      [parity_xcvr_pkg::BUS_W-1:0] s2_a_out,
    output logic                       s2_a_oe,
    input  wire logic [parity_xcvr_pkg::BUS_W-1:0] s2_b_in,
    output logic      [parity_xcvr_pkg::BUS_W-1:0] s2_b_out,
    output logic                       s2_b_oe,
    input  wire logic                  section2_check_bit_in,
    output logic                       section2_check_bit_out,
    output logic                       section2_check_bit_oe,
    input  wire logic                  section2_sample_clock,
    input  wire logic                  section2_flag_clear_n,
    output logic                       section2_parity_fault_n_out,
    output logic                       section2_parity_fault_n_oe,
    // fault word stream from both sections
    output logic                       fault_valid,
    input  wire logic                  fault_ready,
    output logic [1:0]                 fault_word,
    output logic                       fault_overrun
);
    import parity_xcvr_pkg::*;

    // high when count of ones is odd
    function automatic logic odd_ones(input logic [WORD_W-1:0] v);
        return ^v;
    endfunction : odd_ones

    xfer_mode_t  mode;
    logic [1:0]  chk;
    logic [1:0]  edge_seen;
    logic [1:0]  clr_n;
    logic [1:0]  sclk;
    logic [1:0]  sclk_d;
    logic [1:0]  next_sclk_d;
    logic [1:0]  flag;
    logic [1:0]  next_flag;
    logic [1:0]  fell;
    logic        fifo_in_ready;
    logic        push;
    logic [WORD_W-1:0] fifo_out;
    logic        overrun;
    logic        next_overrun;

    always_comb begin
        case ({b_side_drive_enable_n, a_side_drive_enable_n})
            2'b01:   mode = MODE_A_TO_B;
            2'b10:   mode = MODE_B_TO_A;
            2'b11:   mode = MODE_ISOLATE;
            default: mode = MODE_A_TO_B_INV;
        endcase
    end

    // bus drive; outside logic owns undriven lines
    always_comb begin
        s1_a_out = s1_b_in;
        s2_a_out = s2_b_in;
        s1_b_out = s1_a_in;
        s2_b_out = s2_a_in;
        s1_a_oe  = (mode == MODE_B_TO_A);
        s2_a_oe  = s1_a_oe;
        s1_b_oe  = (mode == MODE_A_TO_B) || (mode == MODE_A_TO_B_INV);
        s2_b_oe  = s1_b_oe;
        section1_check_bit_oe = s1_b_oe;
        section2_check_bit_oe = s1_b_oe;
        // odd parity generation, inverted in diagnostic mode
        section1_check_bit_out = odd_ones({1'b0, s1_a_in})
                                 ^ (mode == MODE_A_TO_B);
        section2_check_bit_out = odd_ones({1'b0, s2_a_in})
                                 ^ (mode == MODE_A_TO_B);
    end

    // check result; in isolation it is odd parity of A
    always_comb begin
        if (mode == MODE_ISOLATE) begin
            chk[0] = odd_ones({1'b0, s1_a_in});
            chk[1] = odd_ones({1'b0, s2_a_in});
        end else begin
            chk[0] = odd_ones({section1_check_bit_in, s1_b_in});
            chk[1] = odd_ones({section2_check_bit_in, s2_b_in});
        end
        sclk      = {section2_sample_clock, section1_sample_clock};
        clr_n     = {section2_flag_clear_n, section1_flag_clear_n};
        edge_seen = sclk & ~sclk_d;
        next_sclk_d = sclk;
        for (int i = 0; i < 2; i++) begin
            if (!clr_n[i]) begin
                next_flag[i] = FLAG_RST;
            end else if (edge_seen[i]) begin
                next_flag[i] = flag[i] & chk[i];
            end else begin
                next_flag[i] = flag[i];
            end
        end
        fell  = flag & ~next_flag;
        push  = (|fell) && fifo_in_ready;
        next_overrun = overrun | ((|fell) && !fifo_in_ready);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flag    <= {2{FLAG_RST}};
            sclk_d  <= '0;
            overrun <= 1'b0;
        end else begin
            flag    <= next_flag;
            sclk_d  <= next_sclk_d;
            overrun <= next_overrun;
        end
    end

    // open drain flag pins
    always_comb begin
        section1_parity_fault_n_out = 1'b0;
        section2_parity_fault_n_out = 1'b0;
        section1_parity_fault_n_oe  = ~flag[0];
        section2_parity_fault_n_oe  = ~flag[1];
        fault_overrun               = overrun;
    end

    word_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({{(WORD_W-2){1'b0}}, fell}),
        .out_valid (fault_valid),
        .out_ready (fault_ready),
        .out_data  (fifo_out)
    );
    assign fault_word = fifo_out[1:0];

    property p_clear_forces_high;
        @(posedge clk) disable iff (!rst_n)
        !section1_flag_clear_n |=> !section1_parity_fault_n_oe;
    endproperty
    a_clear_forces_high: assert property (p_clear_forces_high)
        else $error("flag not released under clear");

    sequence s_edge_bad;
        section1_flag_clear_n && section1_sample_clock && !sclk_d[0]
            && !chk[0];
    endsequence
    property p_error_sets;
        @(posedge clk) disable iff (!rst_n)
        s_edge_bad |=> section1_parity_fault_n_oe;
    endproperty
    a_error_sets: assert property (p_error_sets)
        else $error("bad parity did not set flag");

    property p_sticky;
        @(posedge clk) disable iff (!rst_n)
        (section1_parity_fault_n_oe && section1_flag_clear_n)
            |=> section1_parity_fault_n_oe;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without clear");

    property p_no_edge_hold;
        @(posedge clk) disable iff (!rst_n)
        (!(section2_sample_clock && !sclk_d[1]) && section2_flag_clear_n)
            |=> $stable(section2_parity_fault_n_oe);
    endproperty
    a_no_edge_hold: assert property (p_no_edge_hold)
        else $error("flag changed without edge");

    property p_isolate;
        @(posedge clk) disable iff (!rst_n)
        (mode == MODE_ISOLATE) |-> !(s1_a_oe || s1_b_oe
            || section1_check_bit_oe);
    endproperty
    a_isolate: assert property (p_isolate)
        else $error("bus driven in isolation");

    property p_gen_parity;
        @(posedge clk) disable iff (!rst_n)
        (mode == MODE_A_TO_B) |->
            (^{section1_check_bit_out, s1_b_out}) && s1_b_out == s1_a_in;
    endproperty
    a_gen_parity: assert property (p_gen_parity)
        else $error("generated parity not odd");

    property p_inv_parity;
        @(posedge clk) disable iff (!rst_n)
        (mode == MODE_A_TO_B_INV) |->
            !(^{section1_check_bit_out, s1_b_out});
    endproperty
    a_inv_parity: assert property (p_inv_parity)
        else $error("diagnostic parity not inverted");

    property p_b_to_a;
        @(posedge clk) disable iff (!rst_n)
        (mode == MODE_B_TO_A) |-> s1_a_oe && s1_a_out == s1_b_in
            && !section1_check_bit_oe;
    endproperty
    a_b_to_a: assert property (p_b_to_a)
        else $error("B to A path wrong");

    property p_open_drain;
        @(posedge clk) disable iff (!rst_n)
        !section1_parity_fault_n_out && !section2_parity_fault_n_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("flag driven high");

    property p_iso_flag;
        @(posedge clk) disable iff (!rst_n)
        (mode == MODE_ISOLATE && section1_flag_clear_n
            && section1_sample_clock && !sclk_d[0] && !(^s1_a_in))
            |=> section1_parity_fault_n_oe;
    endproperty
    a_iso_flag: assert property (p_iso_flag)
        else $error("isolation flag not from A parity");
endmodule : dual_parity_bus_transceiver

// ---- verification/far_bus.sv ----
// far-side bus logic for one section of the transceiver
`timescale 1ns/10ps
module far_bus (
    // device drive
    input  wire logic [7:0] a_out,
    input  wire logic       a_oe,
    input  wire logic [7:0] b_out,
    input  wire logic       b_oe,
    input  wire logic       p_out,
    input  wire logic       p_oe,
    // far-side values
    input  wire logic [7:0] a_val,
    input  wire logic [7:0] b_val,
    input  wire logic       p_val,
    // resolved wire levels
    output logic      [7:0] a_wire,
    output logic      [7:0] b_wire,
    output logic            p_wire
);
    // far logic drives only the lines the device has released
    assign a_wire = a_oe ? a_out : a_val;
    assign b_wire = b_oe ? b_out : b_val;
    assign p_wire = p_oe ? p_out : p_val;
endmodule : far_bus

// ---- verification/test_dual_parity_bus_transceiver.sv ----
// self-checking bench for the dual parity bus transceiver
`timescale 1ns/10ps
module test_dual_parity_bus_transceiver;
    import parity_xcvr_pkg::*;
    logic clk, rst_n, ena_n, enb_n, fr, fv, fovr;
    logic [1:0] fw;
    logic [1:0] q[$];
    logic [BUS_W-1:0] ao[2], bo[2], aw[2], bw[2], av[2], bv[2];
    logic ae[2], be[2], po[2], pe[2], pw[2], pv[2];
    logic sc[2], cl_n[2], fo[2], fe[2], ef[2];
    int err_total, total_checks, cyc, seed;

    dual_parity_bus_transceiver dut (
        .clk(clk), .rst_n(rst_n), .a_side_drive_enable_n(ena_n),
        .b_side_drive_enable_n(enb_n),
        .s1_a_in(aw[0]), .s1_a_out(ao[0]), .s1_a_oe(ae[0]),
        .s1_b_in(bw[0]), .s1_b_out(bo[0]), .s1_b_oe(be[0]),
        .section1_check_bit_in(pw[0]), .section1_check_bit_out(po[0]),
        .section1_check_bit_oe(pe[0]), .section1_sample_clock(sc[0]),
        .section1_flag_clear_n(cl_n[0]),
        .section1_parity_fault_n_out(fo[0]),
        .section1_parity_fault_n_oe(fe[0]),
        .s2_a_in(aw[1]), .s2_a_out(ao[1]), .s2_a_oe(ae[1]),
        .s2_b_in(bw[1]), .s2_b_out(bo[1]), .s2_b_oe(be[1]),
        .section2_check_bit_in(pw[1]), .section2_check_bit_out(po[1]),
        .section2_check_bit_oe(pe[1]), .section2_sample_clock(sc[1]),
        .section2_flag_clear_n(cl_n[1]),
        .section2_parity_fault_n_out(fo[1]),
        .section2_parity_fault_n_oe(fe[1]),
        .fault_valid(fv), .fault_ready(fr), .fault_word(fw),
        .fault_overrun(fovr)
    );

    for (genvar i = 0; i < 2; i++) begin : g_far
        far_bus far (.a_out(ao[i]), .a_oe(ae[i]), .b_out(bo[i]),
            .b_oe(be[i]), .p_out(po[i]), .p_oe(pe[i]), .a_val(av[i]),
            .b_val(bv[i]), .p_val(pv[i]), .a_wire(aw[i]),
            .b_wire(bw[i]), .p_wire(pw[i]));
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, exp, input string m);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %0t: %s", $time, m);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    function automatic logic [7:0] rnd8();
        int r;
        r = $random(seed);
        return r[7:0];
    endfunction : rnd8

    // one sample edge with the check result forced to the value of good
    task automatic ev(input int i, input logic good);
        logic [7:0] a, b;
        a = rnd8();
        b = rnd8();
        a[0] = a[0] ^ (^a) ^ good;
        if (!good && !ef[i] && !(fr === 1'b0 && q.size() == FIFO_DEPTH))
            q.push_back(2'(1 << i));
        ef[i] = ef[i] | !good;
        @(posedge clk);
        av[i] <= a;
        bv[i] <= b;
        pv[i] <= good ^ (^b) ^ (enb_n & ena_n);
        @(posedge clk) sc[i] <= 1'b1;
        repeat (3) @(posedge clk);
        sc[i] <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(fe[i], ef[i], "flag");
        if (fe[i] === 1'b1) chk(fo[i], 1'b0, "pull low");
    endtask : ev

    task automatic clr(input int i);
        @(posedge clk) cl_n[i] <= 1'b0;
        @(posedge clk) cl_n[i] <= 1'b1;
        ef[i] = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(fe[i], 1'b0, "clear");
    endtask : clr

    task automatic bus_chk();
        logic [1:0] m;
        m = {enb_n, ena_n};
        for (int i = 0; i < 2; i++) begin
            chk(be[i], !enb_n, "b drive");
            chk(pe[i], !enb_n, "parity drive");
            chk(ae[i], m == 2'b10, "a drive");
            if (!enb_n) chk(bo[i], av[i], "b data");
            if (m == 2'b01) chk(po[i], ~^av[i], "parity");
            if (m == 2'b00) chk(po[i], ^av[i], "inv parity");
            if (m == 2'b10) chk(ao[i], bv[i], "a data");
        end
    endtask : bus_chk

    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            end_of_test();
        end
    end

    // settled handshake is looked at between edges; a pop lands next edge
    always @(negedge clk) begin
        if (rst_n === 1'b1 && fv === 1'b1 && fr === 1'b1) begin
            if (q.size() == 0) begin
                err_total++;
                $display("unexpected %0t: extra fault word", $time);
            end else begin
                chk(fw, q.pop_front(), "fault word");
            end
        end
    end

    initial begin
        seed = 97;
        {rst_n, ena_n, enb_n, fr} = 4'h7;
        for (int i = 0; i < 2; i++) begin
            {av[i], bv[i], pv[i], sc[i], cl_n[i], ef[i]} = 20'h00002;
        end
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            repeat (3) begin
                @(posedge clk);
                {enb_n, ena_n} <= 2'(m);
                for (int i = 0; i < 2; i++) begin
                    av[i] <= rnd8();
                    bv[i] <= rnd8();
                end
                @(posedge clk);
                #1;
                bus_chk();
            end
        end
        $display("test modes done");
        @(posedge clk) {enb_n, ena_n} <= 2'b10;
        for (int n = 0; n < 8; n++) ev(n % 2, rnd8() > 8'h80);
        clr(0);
        clr(1);
        ev(0, 1'b0);
        ev(0, 1'b1);
        clr(0);
        @(posedge clk);
        cl_n[0] <= 1'b0;
        bv[0] <= 8'h00;
        pv[0] <= 1'b0;
        @(posedge clk) sc[0] <= 1'b1;
        repeat (3) @(posedge clk);
        sc[0] <= 1'b0;
        cl_n[0] <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(fe[0], 1'b0, "clear wins");
        $display("test check done");
        @(posedge clk) {enb_n, ena_n} <= 2'b11;
        for (int n = 0; n < 4; n++) begin
            ev(n % 2, n > 1);
            clr(n % 2);
        end
        $display("test isolate done");
        @(posedge clk) {enb_n, ena_n} <= 2'b10;
        fr <= 1'b0;
        for (int k = 0; k < FIFO_DEPTH + 1; k++) begin
            ev(k % 2, 1'b0);
            clr(k % 2);
        end
        chk(fovr, 1'b1, "overrun");
        chk(fv, 1'b1, "fifo valid");
        @(posedge clk) fr <= 1'b1;
        for (int n = 0; n < 20 && q.size() > 0; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
        chk(fv, 1'b0, "fifo empty");
        chk(q.size() == 0, 1'b1, "all drained");
        $display("test fifo done");
        end_of_test();
    end
endmodule : test_dual_parity_bus_transceiver
